// *** inc/lpd_link_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface lpd_link_if #(
    parameter int LANES = lpd_pkg::LPD_LANES_WIDE
);
    logic fwdClkOut;
    logic fwdClkOe;
    logic [LANES-1:0] laneOut;
    logic [LANES-1:0] laneOe;
    logic forwardedClockIn;
    logic [LANES-1:0] serialLaneIn;

    // undriven inputs bias high, like a failsafe receiver
    assign forwardedClockIn = fwdClkOe ? fwdClkOut : 1'b1;
    assign serialLaneIn = laneOut | ~laneOe;

    modport tx (output fwdClkOut, output fwdClkOe, output laneOut, output laneOe);
    modport rx (input forwardedClockIn, input serialLaneIn);
endinterface : lpd_link_if
`default_nettype wire

// *** inc/lpd_pkg.sv ***
// Behaviour
// - wide: four lanes to 28 outputs
// - narrow: three lanes to 21 outputs
// - sample seven bit slots per clock period
// - outputs valid at output clock falling edge
// - sleep low forces every output low
// - sleep reaches outputs within 1 us
// - lock within 10 ms; data invalid before
// - forwarded clock held within supported range
// - output clock has 50 percent duty
// - output period equals input clock period
// - floating lanes with clock: outputs high
// - floating lanes and clock: outputs hold
// - floating forwarded clock: output clock high
// - wide: 8 bits per colour, three syncs
// - bit-to-signal mapping agreed by both ends
package lpd_pkg;
    // =====================================================
    // link shape
    localparam int LPD_LANES_WIDE = 4;
    localparam int LPD_LANES_NARROW = 3;
    localparam int LPD_BITS_PER_LANE = 7;
    localparam int LPD_MAX_OUT = 28;
    localparam int LPD_COLOUR_BITS_WIDE = 8;
    localparam int LPD_COLOUR_BITS_NARROW = 6;
    // clock slot where the forwarded clock goes low
    localparam int LPD_CLK_HIGH_SLOTS = 4;
    // =====================================================
    // timing
    localparam int LPD_CLK_MHZ = 50;
    localparam int LPD_SLEEP_ENTRY_NS = 1000;
    localparam int LPD_SLEEP_ENTRY_CYC = LPD_SLEEP_ENTRY_NS * LPD_CLK_MHZ / 1000;
    localparam int LPD_LOCK_TIME_MS = 10;
    localparam int LPD_LOCK_TIME_CYC = LPD_LOCK_TIME_MS * 1000 * LPD_CLK_MHZ * 1000 / 1000;
    localparam int LPD_FWD_MIN_MHZ = 20;
    localparam int LPD_FWD_MAX_MHZ = 65;
    localparam int LPD_OUT_PERIOD_MAX_NS = 50;
    // sampled model: at least two clk cycles per serial bit
    localparam int LPD_MIN_PERIOD_CYC = 14;
    localparam int LPD_MAX_PERIOD_CYC = 255;
    localparam int LPD_LOCK_EDGES = 4;
    localparam int LPD_BIT_CYCLES = 4;
    // =====================================================
    // reset values
    localparam logic LPD_IDLE_LEVEL = 1'b1;
    localparam logic LPD_SLEEP_RESET = 1'b0;

    typedef logic [LPD_MAX_OUT-1:0][4:0] lpd_map_t;

    function automatic lpd_map_t lpd_identity_map();
        lpd_map_t m;
        for (int i = 0; i < LPD_MAX_OUT; i++) begin
            m[i] = 5'(i);
        end
        return m;
    endfunction : lpd_identity_map

    localparam lpd_map_t LPD_DEFAULT_MAP = lpd_identity_map();
endpackage : lpd_pkg

// *** logic/lpd_receiver.sv ***
`timescale 1ns/1ns
`default_nettype none
module lpd_receiver #(
    parameter int LANES = lpd_pkg::LPD_LANES_WIDE,
    parameter lpd_pkg::lpd_map_t BIT_MAP = lpd_pkg::LPD_DEFAULT_MAP,
    parameter int LOCK_CYCLES = lpd_pkg::LPD_LOCK_TIME_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    lpd_link_if.rx link,
    input wire logic sleep_n,
    output logic pixelClockOut,
    output logic [7*LANES-1:0] parallelPixelOut,
    output logic lineSync,
    output logic frameSync,
    output logic pixelValid,
    output logic spareControl,
    output logic locked
);
    import lpd_pkg::*;
    localparam int NOUT = LPD_BITS_PER_LANE * LANES;
    localparam int CBITS = (LANES == LPD_LANES_WIDE) ? LPD_COLOUR_BITS_WIDE : LPD_COLOUR_BITS_NARROW;
    localparam int POS_LINE = 3 * CBITS;
    localparam int NSYNC = LANES + 2;
    localparam int IDX_CLK = LANES;
    localparam int IDX_SLEEP = LANES + 1;

    if (LANES != LPD_LANES_WIDE && LANES != LPD_LANES_NARROW) begin : g_bad_lanes
        $error("lanes must be three or four");
    end
    if ((LPD_LOCK_EDGES + 2) * LPD_MAX_PERIOD_CYC > LOCK_CYCLES) begin : g_bad_lock
        $error("lock cannot finish in the lock time");
    end
    if (4 > LPD_SLEEP_ENTRY_CYC) begin : g_bad_sleep
        $error("sleep path slower than entry delay");
    end

    // =====================================================
    // input synchronisers, change taken when stages 2 and 3 agree
    logic [NSYNC-1:0] rawIn;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    logic [NSYNC-1:0] syncC;
    logic [NSYNC-1:0] filtReg;
    localparam logic [NSYNC-1:0] FILT_RESET = {LPD_SLEEP_RESET, {(LANES + 1){LPD_IDLE_LEVEL}}};
    assign rawIn = {sleep_n, link.forwardedClockIn, link.serialLaneIn};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= FILT_RESET;
            syncB <= FILT_RESET;
            syncC <= FILT_RESET;
        end else begin
            syncA <= rawIn;
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filtReg <= FILT_RESET;
        end else begin
            for (int i = 0; i < NSYNC; i++) begin
                if (syncB[i] == syncC[i]) begin
                    filtReg[i] <= syncC[i];
                end
            end
        end
    end

    logic asleep;
    logic fwdPrevReg;
    logic fwdRise;
    assign asleep = !filtReg[IDX_SLEEP];
    assign fwdRise = filtReg[IDX_CLK] && !fwdPrevReg;

    // =====================================================
    // period measurement and clock loss
    logic [15:0] phaseReg;
    logic [15:0] periodReg;
    logic clockLost;
    logic [15:0] measured;
    logic periodOk;
    assign measured = phaseReg + 16'h0001;
    assign clockLost = (phaseReg >= 16'(2 * LPD_MAX_PERIOD_CYC));
    assign periodOk = (measured >= 16'(LPD_MIN_PERIOD_CYC)) && (measured <= 16'(LPD_MAX_PERIOD_CYC))
                      && (measured <= periodReg + 16'h0001) && (measured + 16'h0001 >= periodReg);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fwdPrevReg <= LPD_IDLE_LEVEL;
            phaseReg <= 16'h0000;
            periodReg <= 16'h0000;
        end else begin
            fwdPrevReg <= filtReg[IDX_CLK];
            if (fwdRise) begin
                phaseReg <= 16'h0000;
                periodReg <= measured;
            end else if (!clockLost) begin
                phaseReg <= phaseReg + 16'h0001;
            end
        end
    end

    // =====================================================
    // lock: several agreeing periods in a row
    logic [3:0] goodReg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            goodReg <= 4'h0;
            locked <= 1'b0;
        end else if (asleep || clockLost) begin
            goodReg <= 4'h0;
            locked <= 1'b0;
        end else if (fwdRise) begin
            if (!periodOk) begin
                goodReg <= 4'h0;
                locked <= 1'b0;
            end else if (goodReg == 4'(LPD_LOCK_EDGES)) begin
                locked <= 1'b1;
            end else begin
                goodReg <= goodReg + 4'h1;
            end
        end
    end

    // =====================================================
    // bit slots: slot k sampled at (k + 1/2) of period / 7
    logic [2:0] slotReg;
    logic [19:0] phaseScaled;
    logic [19:0] target;
    logic sampleNow;
    logic frameDone;
    logic [NOUT-1:0] serialReg;
    assign phaseScaled = 20'(phaseReg) * 20'(2 * LPD_BITS_PER_LANE);
    assign target = 20'({slotReg, 1'b1}) * 20'(periodReg);
    assign sampleNow = !fwdRise && (slotReg < 3'(LPD_BITS_PER_LANE)) && (phaseScaled >= target);
    assign frameDone = sampleNow && (slotReg == 3'(LPD_BITS_PER_LANE - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slotReg <= 3'(LPD_BITS_PER_LANE);
            serialReg <= '0;
        end else if (fwdRise) begin
            slotReg <= 3'h0;
        end else if (sampleNow) begin
            slotReg <= slotReg + 3'h1;
            for (int l = 0; l < LANES; l++) begin
                // idle-high lanes land here as all ones
                serialReg[l * LPD_BITS_PER_LANE + int'(slotReg)] <= filtReg[l];
            end
        end
    end

    // =====================================================
    // output word via the map; last bit taken from the pin directly
    logic [NOUT-1:0] fullWord;
    logic [NOUT-1:0] mappedWord;
    always_comb begin
        fullWord = serialReg;
        for (int l = 0; l < LANES; l++) begin
            fullWord[l * LPD_BITS_PER_LANE + LPD_BITS_PER_LANE - 1] = filtReg[l];
        end
    end

    for (genvar j = 0; j < NOUT; j++) begin : g_map
        assign mappedWord[j] = fullWord[BIT_MAP[j]];
    end

    logic update;
    assign update = frameDone && locked && !asleep;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            parallelPixelOut <= '0;
            lineSync <= 1'b0;
            frameSync <= 1'b0;
            pixelValid <= 1'b0;
            spareControl <= 1'b0;
        end else if (asleep) begin
            parallelPixelOut <= '0;
            lineSync <= 1'b0;
            frameSync <= 1'b0;
            pixelValid <= 1'b0;
            spareControl <= 1'b0;
        end else if (update) begin
            // a lost clock never reaches here, so the word holds
            parallelPixelOut <= mappedWord;
            lineSync <= mappedWord[POS_LINE];
            frameSync <= mappedWord[POS_LINE + 1];
            pixelValid <= mappedWord[POS_LINE + 2];
            spareControl <= (LANES == LPD_LANES_WIDE) ? mappedWord[NOUT - 1] : 1'b0;
        end
    end

    // =====================================================
    // output clock: rises with new data, falls half a period later
    logic [15:0] halfReg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pixelClockOut <= 1'b0;
            halfReg <= 16'h0000;
        end else if (asleep) begin
            pixelClockOut <= 1'b0;
            halfReg <= 16'h0000;
        end else if (clockLost) begin
            pixelClockOut <= 1'b1;
            halfReg <= 16'h0000;
        end else if (update) begin
            pixelClockOut <= 1'b1;
            halfReg <= periodReg >> 1;
        end else if (halfReg > 16'h0001) begin
            halfReg <= halfReg - 16'h0001;
        end else if (halfReg == 16'h0001) begin
            halfReg <= 16'h0000;
            pixelClockOut <= 1'b0;
        end
    end
endmodule : lpd_receiver
`default_nettype wire

// *** logic/lpd_transmitter.sv ***
`timescale 1ns/1ns
`default_nettype none
module lpd_transmitter #(
    parameter int LANES = lpd_pkg::LPD_LANES_WIDE,
    parameter lpd_pkg::lpd_map_t BIT_MAP = lpd_pkg::LPD_DEFAULT_MAP,
    parameter int BIT_CYCLES = lpd_pkg::LPD_BIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    lpd_link_if.tx link,
    input wire logic [7*LANES-1:0] pixelIn,
    input wire logic clockEnable,
    input wire logic dataEnable,
    output logic frameTaken
);
    import lpd_pkg::*;
    localparam int NOUT = LPD_BITS_PER_LANE * LANES;

    if (LANES != LPD_LANES_WIDE && LANES != LPD_LANES_NARROW) begin : g_bad_lanes
        $error("lanes must be three or four");
    end
    if (LPD_BITS_PER_LANE * BIT_CYCLES < LPD_MIN_PERIOD_CYC
        || LPD_BITS_PER_LANE * BIT_CYCLES > LPD_MAX_PERIOD_CYC) begin : g_bad_rate
        $error("forwarded clock period out of range");
    end

    // =====================================================
    // bit divider
    logic [7:0] divReg;
    logic [2:0] slotReg;
    logic slotStart;
    assign slotStart = (divReg == 8'(BIT_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divReg <= 8'h00;
            // start on the last slot so the first rise opens a full frame
            slotReg <= 3'(LPD_BITS_PER_LANE - 1);
        end else if (slotStart) begin
            divReg <= 8'h00;
            slotReg <= (slotReg == 3'(LPD_BITS_PER_LANE - 1)) ? 3'h0 : slotReg + 3'h1;
        end else begin
            divReg <= divReg + 8'h01;
        end
    end

    // =====================================================
    // word capture, serial order set by the shared map
    logic [NOUT-1:0] serialWord;
    logic [NOUT-1:0] wordReg;
    logic loadNow;
    assign loadNow = slotStart && (slotReg == 3'(LPD_BITS_PER_LANE - 1));

    for (genvar j = 0; j < NOUT; j++) begin : g_map
        assign serialWord[BIT_MAP[j]] = pixelIn[j];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wordReg <= '0;
            frameTaken <= 1'b0;
        end else begin
            frameTaken <= loadNow;
            if (loadNow) begin
                wordReg <= serialWord;
            end
        end
    end

    // =====================================================
    // pins: clock high for slots 0..3, bit 0 first after the rise
    logic [2:0] nextSlot;
    assign nextSlot = (slotReg == 3'(LPD_BITS_PER_LANE - 1)) ? 3'h0 : slotReg + 3'h1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link.fwdClkOut <= 1'b0;
            link.fwdClkOe <= 1'b0;
            link.laneOut <= '0;
            link.laneOe <= '0;
        end else begin
            link.fwdClkOe <= clockEnable;
            link.laneOe <= {LANES{dataEnable}};
            if (slotStart) begin
                link.fwdClkOut <= (nextSlot < 3'(LPD_CLK_HIGH_SLOTS));
                for (int l = 0; l < LANES; l++) begin
                    link.laneOut[l] <= (nextSlot == 3'h0) ? serialWord[l * LPD_BITS_PER_LANE]
                                                          : wordReg[l * LPD_BITS_PER_LANE + int'(nextSlot)];
                end
            end
        end
    end
endmodule : lpd_transmitter
`default_nettype wire

// *** verification/lpd_link_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module lpd_link_properties #(
    parameter int LANES = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fwdClkOut,
    input wire logic fwdClkOe,
    input wire logic [LANES-1:0] laneOut,
    input wire logic [LANES-1:0] laneOe,
    input wire logic sleep_n,
    input wire logic pixelClockOut,
    input wire logic [7*LANES-1:0] parallelPixelOut,
    input wire logic locked
);
    // =====================================================
    // helper counters
    logic [9:0] sleepCnt;
    logic [9:0] noClkCnt;
    logic [9:0] floatCnt;
    logic [9:0] lockWait;

    // saturate so a long idle never wraps back under a threshold
    function automatic logic [9:0] bump(input logic [9:0] c, input logic clr);
        return clr ? 10'h0 : c + 10'(c != 10'h3FF);
    endfunction : bump

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleepCnt <= 10'h0;
            noClkCnt <= 10'h0;
            floatCnt <= 10'h0;
            lockWait <= 10'h0;
        end else begin
            sleepCnt <= bump(sleepCnt, sleep_n);
            noClkCnt <= bump(noClkCnt, fwdClkOe);
            floatCnt <= bump(floatCnt, |laneOe || !fwdClkOe);
            lockWait <= bump(lockWait, locked || !fwdClkOe || !sleep_n);
        end
    end

    // =====================================================
    // properties
    clock_slot_timing_a: assert property (@(posedge clk) disable iff (!rst_n || !fwdClkOe)
        $rose(fwdClkOut) |-> ##15 fwdClkOut ##1 !fwdClkOut ##11 !fwdClkOut ##1 fwdClkOut)
        else $error("forwarded clock slots wrong");
    out_clock_duty_a: assert property (@(posedge clk) disable iff (!rst_n || !sleep_n || !fwdClkOe)
        $rose(pixelClockOut) |-> ##13 pixelClockOut ##1 !pixelClockOut ##13 !pixelClockOut ##1 pixelClockOut)
        else $error("output clock duty or period wrong");
    sleep_outputs_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        sleepCnt >= 10'd50 |-> parallelPixelOut == '0 && !pixelClockOut && !locked)
        else $error("outputs not low in sleep");
    float_lanes_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        floatCnt >= 10'd80 && sleep_n && locked |-> &parallelPixelOut)
        else $error("floating lanes not all high");
    lost_clock_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        noClkCnt >= 10'd600 && sleep_n |-> pixelClockOut)
        else $error("output clock not high without clock");
    lost_clock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        noClkCnt >= 10'd20 && laneOe == '0 && sleep_n |=> $stable(parallelPixelOut))
        else $error("data moved without clock");
    update_needs_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(parallelPixelOut) && sleep_n |-> locked)
        else $error("data updated while unlocked");
    lock_time_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        lockWait < 10'd300)
        else $error("lock took too long");
    strobe_on_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(parallelPixelOut) && sleep_n |-> $rose(pixelClockOut))
        else $error("data changed away from strobe rise");
endmodule : lpd_link_properties
`default_nettype wire

// *** verification/lvds_pixel_deserializer_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`define LPD_CHECK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
        end \
    end
module lvds_pixel_deserializer_tb_top;
    import lpd_pkg::*;
    function automatic lpd_map_t rev_map();
        lpd_map_t m;
        m = LPD_DEFAULT_MAP;
        for (int i = 0; i < 21; i++) begin
            m[i] = 5'(20 - i);
        end
        return m;
    endfunction : rev_map
    localparam lpd_map_t NARROW_MAP = rev_map();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sleep_n = 1'b1;
    logic clkEn = 1'b1;
    logic datEn = 1'b1;
    logic [27:0] pixW = 28'h0;
    logic [27:0] pixOut;
    logic [20:0] narOut;
    logic [4:0] narCtl;
    logic pixClk, narClk, lineSync, frameSync, pixelValid, spareControl, locked;
    logic taken;
    logic [27:0] words [5] = '{28'h0000000, 28'hFFFFFFF, 28'hA5C3F0E, 28'h1234567, 28'h8000001};
    int fails = 0;
    int total_checks = 0;

    always #10 clk = ~clk;

    lpd_link_if wideLink ();
    lpd_link_if #(.LANES(3)) narLink ();
    lpd_transmitter u_lpd_transmitter (.clk(clk), .rst_n(rst_n), .link(wideLink), .pixelIn(pixW),
        .clockEnable(clkEn), .dataEnable(datEn), .frameTaken(taken));
    lpd_receiver u_lpd_receiver (.clk(clk), .rst_n(rst_n), .link(wideLink),
        .sleep_n(sleep_n), .pixelClockOut(pixClk), .parallelPixelOut(pixOut), .lineSync(lineSync),
        .frameSync(frameSync), .pixelValid(pixelValid), .spareControl(spareControl), .locked(locked));
    // custom map on both narrow ends; they must agree
    lpd_transmitter #(.LANES(3), .BIT_MAP(NARROW_MAP)) u_lpd_transmitter_narrow (.clk(clk), .rst_n(rst_n),
        .link(narLink), .pixelIn(pixW[20:0]), .clockEnable(clkEn), .dataEnable(datEn), .frameTaken());
    lpd_receiver #(.LANES(3), .BIT_MAP(NARROW_MAP)) u_lpd_receiver_narrow (.clk(clk),
        .rst_n(rst_n), .link(narLink), .sleep_n(sleep_n), .pixelClockOut(narClk), .parallelPixelOut(narOut),
        .lineSync(narCtl[0]), .frameSync(narCtl[1]), .pixelValid(narCtl[2]), .spareControl(narCtl[3]),
        .locked(narCtl[4]));
    lpd_link_properties u_lpd_link_properties (.clk(clk), .rst_n(rst_n),
        .fwdClkOut(wideLink.fwdClkOut), .fwdClkOe(wideLink.fwdClkOe), .laneOut(wideLink.laneOut),
        .laneOe(wideLink.laneOe), .sleep_n(sleep_n), .pixelClockOut(pixClk), .parallelPixelOut(pixOut),
        .locked(locked));

    // =====================================================
    // tasks
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task automatic give_up(input string what);
        fails++;
        $display("unexpected timeout: expected %s, seen none", what);
        complete_run();
    endtask : give_up

    // capture where a panel would: on the strobe's falling edge
    task automatic wait_fall(input int count);
        logic old;
        for (int k = 0; k < count; k++) begin
            for (int n = 0; n <= 600; n++) begin
                old = pixClk;
                @(negedge clk);
                if (old === 1'b1 && pixClk === 1'b0) break;
                if (n == 600) give_up("strobe");
            end
        end
    endtask : wait_fall

    task automatic wait_lock();
        for (int n = 0; n < 400 && locked !== 1'b1; n++) @(negedge clk);
        if (locked !== 1'b1) give_up("lock");
        `LPD_CHECK("locked", 1'b1, locked)
    endtask : wait_lock

    // four strobes cover latch, one serial period and the update
    task automatic send_word(input logic [27:0] w);
        pixW = w;
        wait_fall(4);
        `LPD_CHECK("wide word", w, pixOut)
        `LPD_CHECK("wide syncs", w[27:24], {spareControl, pixelValid, frameSync, lineSync})
        `LPD_CHECK("narrow word", w[20:0], narOut)
        `LPD_CHECK("narrow syncs", 5'h10 | w[20:18], narCtl)
    endtask : send_word

    task automatic wire_check(input logic [27:0] w);
        logic old;
        pixW = w;
        wait_fall(2);
        old = 1'b1;
        for (int n = 0; n <= 100 && !(old === 1'b0 && wideLink.fwdClkOut === 1'b1); n++) begin
            old = wideLink.fwdClkOut;
            @(negedge clk);
        end
        if (wideLink.fwdClkOut !== 1'b1) give_up("clock rise");
        for (int s = 0; s < 7; s++) begin
            `LPD_CHECK("clock slot", 1'(s < 4), wideLink.fwdClkOut)
            `LPD_CHECK("frame taken", 1'(s == 0), taken)
            for (int l = 0; l < 4; l++) `LPD_CHECK("lane bit", w[l*7+s], wideLink.laneOut[l])
            if (s == 0) `LPD_CHECK("narrow lane0", w[20], narLink.laneOut[0])
            repeat (4) @(negedge clk);
        end
    endtask : wire_check

    // =====================================================
    // sequence
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        wait_lock();
        foreach (words[i]) send_word(words[i]);
        $display("test word patterns done");
        wire_check(28'h9B3E5C1);
        $display("test wire order done");
        datEn = 1'b0;
        repeat (120) @(negedge clk);
        `LPD_CHECK("floating lanes", 28'hFFFFFFF, pixOut)
        datEn = 1'b1;
        send_word(28'h0F1E2D3);
        $display("test floating lanes done");
        clkEn = 1'b0;
        datEn = 1'b0;
        repeat (700) @(negedge clk);
        `LPD_CHECK("held word", 28'h0F1E2D3, pixOut)
        `LPD_CHECK("lost clock", 1'b1, pixClk)
        `LPD_CHECK("narrow lost clock", 1'b1, narClk)
        clkEn = 1'b1;
        datEn = 1'b1;
        wait_lock();
        send_word(28'h7654321);
        $display("test lost clock done");
        sleep_n = 1'b0;
        repeat (50) @(negedge clk);
        `LPD_CHECK("sleep outputs", 61'h0, {pixOut, pixClk, narOut, narClk, narCtl, locked, lineSync, frameSync, pixelValid, spareControl})
        repeat (10) @(negedge clk);
        sleep_n = 1'b1;
        wait_lock();
        send_word(28'h3C5A96E);
        $display("test sleep done");
        complete_run();
    end
endmodule : lvds_pixel_deserializer_tb_top
`default_nettype wire
